/* File: sgio_port.sv */
// Six-pin general I/O port: register file, read-back, pad control.
// Assumes a simple synchronous write/read strobe from the core and
// pins sampled on ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "sgio_defines.svh"
module sgio_port
  import sgio_pkg::*;
#(
  parameter int NPINS = `SGIO_NPINS
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  clk_en_in,
  // Register access strobes
  input  wire logic                  wr_en_in,
  input  wire sgio_pkg::sgio_reg_sel_t wr_sel_in,
  input  wire sgio_pkg::sgio_pins_t  wr_data_in,
  input  wire logic                  wr_rmw_in,
  input  wire sgio_pkg::sgio_pins_t  wr_mask_in,
  input  wire logic                  rd_en_in,
  input  wire sgio_pkg::sgio_reg_sel_t rd_sel_in,
  output sgio_pkg::sgio_pins_t       rd_data_out,
  output logic                       rd_valid_out,
  // Global pull-up disable
  input  wire logic                  global_pullup_disable_in,
  // Peripheral takeover per pin
  input  wire sgio_pkg::sgio_pins_t  periph_en_in,
  input  wire sgio_pkg::sgio_pins_t  periph_oe_in,
  input  wire sgio_pkg::sgio_pins_t  periph_do_in,
  // Pads, two-way: input, output, output enable
  input  wire sgio_pkg::sgio_pins_t  pin_in,
  output sgio_pkg::sgio_pins_t       pin_out,
  output sgio_pkg::sgio_pins_t       pin_oe_out,
  output sgio_pkg::sgio_pins_t       slew_lim_out,
  output sgio_pkg::sgio_pins_t       pullup_en_out,
  output sgio_pkg::sgio_pins_t       schmitt_sel_out,
  output sgio_pkg::sgio_pins_t       dig_in_buf_en_out,
  // Conditioned digital levels for other blocks (change detect etc.)
  output sgio_pkg::sgio_pins_t       dig_level_out
);
  import sgio_pkg::*;

  sgio_pins_t pin_direction_bits_r;
  sgio_pins_t output_latch_bits_r;
  sgio_pins_t analog_select_bits_r;
  sgio_pins_t open_drain_select_bits_r;
  sgio_pins_t slew_limit_bits_r;
  sgio_pins_t input_threshold_bits_r;
  sgio_pins_t weak_pullup_enable_bits_r;
  sgio_pins_t pin_sync;
  sgio_pins_t pin_level;
  sgio_pins_t latch_nxt;
  sgio_pins_t rd_nxt;

  // Merge new data into a base through a six-bit mask of per-pin enables
  function automatic sgio_pins_t merge_bits(input sgio_pins_t base,
                                            input sgio_pins_t data,
                                            input sgio_pins_t mask);
    merge_bits = (base & ~mask) | (data & mask);
  endfunction

  function automatic logic sel_is(input sgio_reg_sel_t sel,
                                  input sgio_reg_sel_t want);
    sel_is = (sel == want);
  endfunction

  logic wr_go;
  assign wr_go = clk_en_in && wr_en_in;

  sgio_sync #(
    .WIDTH (NPINS)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .async_in   (pin_in),
    .sync_out   (pin_sync)
  );

  // Analog pins read zero because their input buffer is off
  assign pin_level = pin_sync & ~analog_select_bits_r;

  // Level-register and latch-register writes land in the same latch.
  // With RMW the unmasked bits come from the pins, not the latch,
  // so analog or externally pulled pins can corrupt the latch.
  always_comb begin
    latch_nxt = output_latch_bits_r;
    if (sel_is(wr_sel_in, SGIO_REG_LEVEL) ||
        sel_is(wr_sel_in, SGIO_REG_LATCH)) begin
      if (wr_rmw_in) begin
        latch_nxt = merge_bits(pin_level, wr_data_in, wr_mask_in);
      end else begin
        latch_nxt = wr_data_in;
      end
    end
    latch_nxt = latch_nxt & sgio_pins_t'(`SGIO_LAT_IMPL);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      output_latch_bits_r <= sgio_pins_t'(`SGIO_LAT_RST);
    end else if (wr_go) begin
      output_latch_bits_r <= latch_nxt;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pin_direction_bits_r <= sgio_pins_t'(`SGIO_DIR_RST);
    end else if (wr_go && sel_is(wr_sel_in, SGIO_REG_DIR)) begin
      pin_direction_bits_r <= wr_data_in;
      pin_direction_bits_r[`SGIO_INONLY_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      analog_select_bits_r <= sgio_pins_t'(`SGIO_ANALOG_SELECT_BIT_RST);
    end else if (wr_go && sel_is(wr_sel_in, SGIO_REG_ANALOG_SELECT_BIT)) begin
      analog_select_bits_r <= wr_data_in & sgio_pins_t'(`SGIO_ANALOG_SELECT_BIT_IMPL);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      open_drain_select_bits_r <= sgio_pins_t'(`SGIO_OD_RST);
    end else if (wr_go && sel_is(wr_sel_in, SGIO_REG_OD)) begin
      open_drain_select_bits_r <= wr_data_in & sgio_pins_t'(`SGIO_OD_IMPL);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      slew_limit_bits_r <= sgio_pins_t'(`SGIO_SLEW_RST);
    end else if (wr_go && sel_is(wr_sel_in, SGIO_REG_SLEW)) begin
      slew_limit_bits_r <= wr_data_in & sgio_pins_t'(`SGIO_SLEW_IMPL);
    end
  end

  // Changing this while peripherals run may glitch change detection
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      input_threshold_bits_r <= sgio_pins_t'(`SGIO_THR_RST);
    end else if (wr_go && sel_is(wr_sel_in, SGIO_REG_THR)) begin
      input_threshold_bits_r <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      weak_pullup_enable_bits_r <= sgio_pins_t'(`SGIO_WPU_RST);
    end else if (wr_go && sel_is(wr_sel_in, SGIO_REG_WPU)) begin
      weak_pullup_enable_bits_r <= wr_data_in;
    end
  end

  always_comb begin
    case (rd_sel_in)
      SGIO_REG_DIR:   rd_nxt = pin_direction_bits_r;
      SGIO_REG_LEVEL: rd_nxt = pin_level;
      SGIO_REG_LATCH: rd_nxt = output_latch_bits_r;
      SGIO_REG_ANALOG_SELECT_BIT: rd_nxt = analog_select_bits_r;
      SGIO_REG_OD:    rd_nxt = open_drain_select_bits_r;
      SGIO_REG_SLEW:  rd_nxt = slew_limit_bits_r;
      SGIO_REG_THR:   rd_nxt = input_threshold_bits_r;
      SGIO_REG_WPU:   rd_nxt = weak_pullup_enable_bits_r;
      default:        rd_nxt = '0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= rd_nxt;
      end
    end
  end

  // Threshold, input buffer and conditioned level outputs
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      schmitt_sel_out   <= '0;
      dig_in_buf_en_out <= '0;
      dig_level_out     <= '0;
    end else if (clk_en_in) begin
      schmitt_sel_out   <= ~input_threshold_bits_r;
      dig_in_buf_en_out <= ~analog_select_bits_r;
      dig_level_out     <= pin_level;
    end
  end

  // Analog select is deliberately not an input here: output unaffected
  sgio_pad #(
    .WIDTH (NPINS)
  ) u_pad (
    .ref_clk_in      (ref_clk_in),
    .sys_rst_in      (sys_rst_in),
    .clk_en_in       (clk_en_in),
    .dir_in          (pin_direction_bits_r),
    .lat_in          (output_latch_bits_r),
    .od_in           (open_drain_select_bits_r),
    .slew_in         (slew_limit_bits_r),
    .wpu_in          (weak_pullup_enable_bits_r),
    .wpu_glob_dis_in (global_pullup_disable_in),
    .periph_en_in    (periph_en_in),
    .periph_oe_in    (periph_oe_in),
    .periph_do_in    (periph_do_in),
    .pin_out         (pin_out),
    .pin_oe_out      (pin_oe_out),
    .slew_lim_out    (slew_lim_out),
    .pullup_en_out   (pullup_en_out)
  );

endmodule // sgio_port
`default_nettype wire

/* File: sgio_defines.svh */
// Six-pin general I/O port: register reset values, bit positions, widths.
// Included by the port modules; holds definitions only.
`ifndef SGIO_DEFINES_SVH
`define SGIO_DEFINES_SVH

`define SGIO_NPINS          6
`define SGIO_INONLY_BIT     3
`define SGIO_SYNC_STAGES    2
`define SGIO_DIR_RST        6'h3f
`define SGIO_ANALOG_SELECT_BIT_RST      6'h17
`define SGIO_ANALOG_SELECT_BIT_IMPL     6'h17
`define SGIO_OD_RST         6'h00
`define SGIO_OD_IMPL        6'h37
`define SGIO_SLEW_RST       6'h37
`define SGIO_SLEW_IMPL      6'h37
`define SGIO_THR_RST        6'h00
`define SGIO_WPU_RST        6'h3f
`define SGIO_LAT_RST        6'h00
`define SGIO_LAT_IMPL       6'h37

`endif

/* File: sgio_pkg.sv */
// Types shared by the six-pin general I/O port modules.
// Assumes the defines header is available on the include path.
package sgio_pkg;
  typedef logic [5:0] sgio_pins_t;
  typedef enum logic [2:0] {
    SGIO_REG_DIR   = 3'h0,
    SGIO_REG_LEVEL = 3'h1,
    SGIO_REG_LATCH = 3'h2,
    SGIO_REG_ANALOG_SELECT_BIT = 3'h3,
    SGIO_REG_OD    = 3'h4,
    SGIO_REG_SLEW  = 3'h5,
    SGIO_REG_THR   = 3'h6,
    SGIO_REG_WPU   = 3'h7
  } sgio_reg_sel_t;
endpackage

/* File: sgio_sync.sv */
// Two-stage level synchroniser bank for pin inputs.
// Assumes one clock; first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module sgio_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else if (clk_en_in) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // sgio_sync
`default_nettype wire

/* File: sgio_pad.sv */
// Per-pin pad control: output enable, drive value, pull-up, mode flags.
// Purely registered; inputs are the port's stored configuration plus the peripheral and global pull-up controls.
`timescale 1ns/1ps
`default_nettype none
`include "sgio_defines.svh"
module sgio_pad #(
  parameter int WIDTH = 6
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] dir_in,
  input  wire logic [WIDTH-1:0] lat_in,
  input  wire logic [WIDTH-1:0] od_in,
  input  wire logic [WIDTH-1:0] slew_in,
  input  wire logic [WIDTH-1:0] wpu_in,
  input  wire logic             wpu_glob_dis_in,
  input  wire logic [WIDTH-1:0] periph_en_in,
  input  wire logic [WIDTH-1:0] periph_oe_in,
  input  wire logic [WIDTH-1:0] periph_do_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_out,
  output logic      [WIDTH-1:0] slew_lim_out,
  output logic      [WIDTH-1:0] pullup_en_out
);
  logic [WIDTH-1:0] drv_val;
  logic [WIDTH-1:0] drv_en;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] out_nxt;

  always_comb begin
    // Peripheral owns the pin; latch is cut off from it
    drv_val = (periph_en_in & periph_do_in) | (~periph_en_in & lat_in);
    drv_en  = (periph_en_in & periph_oe_in) |
              (~periph_en_in & ~dir_in);
    drv_en[`SGIO_INONLY_BIT] = 1'b0;
    // Open drain only ever pulls low: a high value floats the pin
    oe_nxt  = drv_en & ~(od_in & drv_val);
    out_nxt = drv_val & ~od_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pin_out       <= '0;
      pin_oe_out    <= '0;
      slew_lim_out  <= WIDTH'(`SGIO_SLEW_RST);
      pullup_en_out <= '0;
    end else if (clk_en_in) begin
      pin_out       <= out_nxt;
      pin_oe_out    <= oe_nxt;
      slew_lim_out  <= slew_in;
      pullup_en_out <= wpu_in & dir_in & {WIDTH{~wpu_glob_dis_in}};
    end
  end
endmodule // sgio_pad
`default_nettype wire

/* File: sgio_port_sva.sv */
// Checker for the six-pin port: pad drive and read-back relations.
// Sees only the port's top-level pins; bound in below.
`timescale 1ns/1ps
`default_nettype none
module sgio_port_sva
  import sgio_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic wr_en_in,
  input wire sgio_pkg::sgio_reg_sel_t wr_sel_in,
  input wire logic [5:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic rd_valid_out,
  input wire logic global_pullup_disable_in,
  input wire logic [5:0] periph_en_in,
  input wire logic [5:0] periph_oe_in,
  input wire logic [5:0] periph_do_in,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_out,
  input wire logic [5:0] pullup_en_out,
  input wire logic [5:0] dig_in_buf_en_out,
  input wire logic [5:0] dig_level_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  in_only_a: assert property (!pin_oe_out[3])
    else $error("input-only pin driven");
  ana_buf_a: assert property (wr_en_in && clk_en_in &&
    wr_sel_in == SGIO_REG_ANALOG_SELECT_BIT ##1 clk_en_in |=>
    dig_in_buf_en_out == ~($past(wr_data_in, 2) & 6'h17))
    else $error("input buffer enable wrong after analog write");
  ana_zero_a: assert property (
    (dig_level_out & ~dig_in_buf_en_out) == 6'h00)
    else $error("analog pin reads high");
  rd_valid_a: assert property (clk_en_in |=>
    rd_valid_out == $past(rd_en_in))
    else $error("read valid not one cycle after read");
  pu_glob_a: assert property (global_pullup_disable_in && clk_en_in |=>
    pullup_en_out == 6'h00)
    else $error("pull-up on while globally disabled");
  pu_out_a: assert property ($past(clk_en_in) &&
    $past(periph_en_in) == 6'h00 |-> (pullup_en_out & pin_oe_out) == 6'h00)
    else $error("pull-up on a driven pin");
  periph_oe_a: assert property ($past(clk_en_in) |-> (pin_oe_out &
    $past(periph_en_in) & ~$past(periph_oe_in)) == 6'h00)
    else $error("pin driven against peripheral");
  periph_do_a: assert property ($past(clk_en_in) |-> ((pin_out ^
    $past(periph_do_in)) & pin_oe_out & $past(periph_en_in)) == 6'h00)
    else $error("peripheral pin not driven with peripheral data");
  ana_reset_a: assert property ($fell(sys_rst_in) && clk_en_in |=>
    dig_in_buf_en_out == 6'h28)
    else $error("analog select not in reset state");
endmodule // sgio_port_sva
bind sgio_port sgio_port_sva u_sva (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .wr_en_in(wr_en_in),
  .wr_sel_in(wr_sel_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in),
  .rd_valid_out(rd_valid_out), .periph_en_in(periph_en_in),
  .global_pullup_disable_in(global_pullup_disable_in),
  .periph_oe_in(periph_oe_in), .periph_do_in(periph_do_in),
  .pin_out(pin_out), .pin_oe_out(pin_oe_out),
  .pullup_en_out(pullup_en_out), .dig_in_buf_en_out(dig_in_buf_en_out),
  .dig_level_out(dig_level_out));
`default_nettype wire

/* File: sgio_board.sv */
// Board model of the six pads: port drive, board source, pull-up.
// Undriven pins with no pull-up float as a pattern changing each clock.
`timescale 1ns/1ps
`default_nettype none
module sgio_board
  import sgio_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire sgio_pins_t drv_in,
  input  wire sgio_pins_t drv_oe_in,
  input  wire sgio_pins_t pullup_in,
  input  wire sgio_pins_t ext_en_in,
  input  wire sgio_pins_t ext_in,
  output sgio_pins_t      level_out
);
  sgio_pins_t float_r = 6'h15;
  always @(posedge ref_clk_in) begin
    float_r <= ~float_r;
  end
  // Port drive wins over the board to keep read-back defined
  assign level_out = (drv_oe_in & drv_in) | (~drv_oe_in & ext_en_in & ext_in)
    | (~drv_oe_in & ~ext_en_in & (pullup_in | float_r));
endmodule // sgio_board
`default_nettype wire

/* File: tb_top.sv */
// Random and directed bench for the six-pin port with a board model.
// Assumes the package, port, checker and board model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
  import sgio_pkg::*;
  logic clk, rst = 1'b1, ce = 1'b1, we = 1'b0, wrmw = 1'b0, re = 1'b0;
  logic glob = 1'b0, rdv;
  sgio_reg_sel_t wsel = SGIO_REG_DIR, rsel = SGIO_REG_DIR;
  sgio_pins_t wd = 6'h00, wm = 6'h00, pe = 6'h00, poe = 6'h00, pdo = 6'h00;
  sgio_pins_t ext = 6'h2a, exten = 6'h3f;
  sgio_pins_t pin, pout, poe_o, slew, pu, smt, bufen, lvl, rdd;
  sgio_pins_t rv [8] = '{6'h3f, 6'h00, 6'h00, 6'h17, 6'h00, 6'h37, 6'h00,
    6'h3f};
  sgio_pins_t im [8] = '{6'h3f, 6'h3f, 6'h37, 6'h17, 6'h37, 6'h37, 6'h3f,
    6'h3f};
  int num_errors = 0, cmp_count = 0, cyc = 0;
  logic [31:0] seed = 32'd29980;
  sgio_port DUT (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(ce),
    .wr_en_in(we), .wr_sel_in(wsel), .wr_data_in(wd), .wr_rmw_in(wrmw),
    .wr_mask_in(wm), .rd_en_in(re), .rd_sel_in(rsel), .rd_data_out(rdd),
    .rd_valid_out(rdv), .global_pullup_disable_in(glob),
    .periph_en_in(pe), .periph_oe_in(poe), .periph_do_in(pdo),
    .pin_in(pin), .pin_out(pout), .pin_oe_out(poe_o), .slew_lim_out(slew),
    .pullup_en_out(pu), .schmitt_sel_out(smt), .dig_in_buf_en_out(bufen),
    .dig_level_out(lvl));
  sgio_board u_board (.ref_clk_in(clk), .drv_in(pout), .drv_oe_in(poe_o),
    .pullup_in(pu), .ext_en_in(exten), .ext_in(ext), .level_out(pin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic sgio_pins_t r6();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[5:0];
  endfunction
  function automatic sgio_pins_t e_val();
    return (pe & pdo) | (~pe & rv[2]);
  endfunction
  function automatic sgio_pins_t e_oe();
    return ((pe & poe) | (~pe & ~rv[0])) & ~(rv[4] & e_val()) & 6'h37;
  endfunction
  function automatic sgio_pins_t e_lvl();
    return ((e_oe() & e_val()) | (~e_oe() & ext)) & ~rv[3];
  endfunction
  task automatic wr(sgio_reg_sel_t s, sgio_pins_t d, logic r, sgio_pins_t m);
    @(posedge clk);
    we <= 1'b1; wsel <= s; wd <= d; wrmw <= r; wm <= m;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(sgio_reg_sel_t s, sgio_pins_t e);
    @(posedge clk);
    re <= 1'b1; rsel <= s;
    @(posedge clk);
    re <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, rdv)
    `CHK(s.name(), e, rdd)
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    sgio_pins_t d, m, lv;
    sgio_reg_sel_t ws;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (int s = 0; s < 8; s++) begin
      rd(sgio_reg_sel_t'(s), s == 1 ? e_lvl() : rv[s]);
    end
    // Undriven input pins must read high through the pull-ups
    exten <= 6'h00;
    wr(SGIO_REG_ANALOG_SELECT_BIT, 6'h00, 1'b0, 6'h00);
    rv[3] = 6'h00;
    repeat (5) @(posedge clk);
    rd(SGIO_REG_LEVEL, 6'h3f);
    @(posedge clk);
    glob <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("pullup_off", 6'h00, pu)
    exten <= 6'h3f;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      pe <= 6'h00;
      for (int s = 0; s < 8; s++) begin
        if (s != 1) begin
          d = (i == 0) ? 6'h00 : r6();
          ws = sgio_reg_sel_t'((s == 2 && i[0]) ? 1 : s);
          wr(ws, d, 1'b0, 6'h00);
          rv[s] = (d & im[s]) | (s == 0 ? 6'h08 : 6'h00);
        end
      end
      pe <= i[1] ? r6() : 6'h00;
      poe <= r6(); pdo <= r6(); ext <= r6(); glob <= ^r6();
      repeat (5) @(posedge clk);
      #1;
      `CHK("oe", e_oe(), poe_o)
      `CHK("out", e_val() & e_oe(), pout & e_oe())
      `CHK("slew", rv[5], slew)
      `CHK("schmitt", ~rv[6], smt)
      `CHK("pullup", rv[7] & rv[0] & {6{~glob}}, pu)
      `CHK("bufen", ~rv[3], bufen)
      `CHK("diglvl", e_lvl(), lvl)
      rd(SGIO_REG_LEVEL, e_lvl());
      rd(SGIO_REG_DIR, rv[0]);
      d = r6(); m = r6(); lv = e_lvl();
      wr(i[0] ? SGIO_REG_LEVEL : SGIO_REG_LATCH, d, 1'b1, m);
      rv[2] = ((lv & ~m) | (d & m)) & 6'h37;
      rd(SGIO_REG_LATCH, rv[2]);
    end
    // Clock enable low must swallow a write and hold the pad drive
    @(posedge clk);
    ce <= 1'b0;
    wr(SGIO_REG_DIR, ~rv[0], 1'b0, 6'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("frozen_oe", e_oe(), poe_o)
    @(posedge clk);
    ce <= 1'b1;
    rd(SGIO_REG_DIR, rv[0]);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
